// ---- hw/flag_bank_pkg.sv ----
// Constants and register layout for the interrupt flag status bank.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
package flag_bank_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_TIMER_GATE = 8'h00;
  localparam logic [7:0] OFS_PORT_TWO   = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          BIT_TIMER_GATE   = 5;
  localparam int          BIT_COLLISION    = 2;
  localparam int          BIT_PORT_EVENT   = 1;
  localparam int          NUM_EVENTS       = 3;
  localparam logic [2:0]  EVENTS_RESET     = 3'h0;
  localparam logic [15:0] REG_RESET        = 16'h0000;

  typedef enum logic [1:0] {
    AHB_IDLE   = 2'h0,
    AHB_BUSY   = 2'h1,
    AHB_NONSEQ = 2'h2,
    AHB_SEQ    = 2'h3
  } htrans_t;

endpackage

// ---- hw/flag_cell.sv ----
// One sticky flag: hardware pulse sets, software write of zero clears.
// Assumes set and write strobes are synchronous to clk.
`timescale 1ns/10ps
module flag_cell
  import flag_bank_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic present,
  input  wire logic setPulse,
  input  wire logic wrEn,
  input  wire logic wrBit,
  output logic      flag
);

  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (wrEn) begin
      flag_nxt = wrBit;
    end
    if (setPulse) begin
      flag_nxt = 1'b1;
    end
    if (!present) begin
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

  a_set_wins: assert property (@(posedge clk) disable iff (srst)
    ce && present && setPulse |=> flag)
    else $error("flag not set after pulse");

endmodule

// ---- hw/ahb_regs_port.sv ----
// AHB-Lite slave front end: captures address phase, gives write strobes.
// Assumes one master, single word transfers; waits only while ce is low, OKAY.
`timescale 1ns/10ps
module ahb_regs_port
  import flag_bank_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             wrValid,
  output logic             rdValid,
  output logic [7:0]       phaseAddr
);

  logic       wr_r;
  logic       wr_nxt;
  logic       rd_r;
  logic       rd_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       take;

  always_comb begin
    take     = hsel && hready && htrans[1];
    wr_nxt   = take && hwrite;
    rd_nxt   = take && !hwrite;
    addr_nxt = take ? haddr : addr_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      addr_r <= 8'h00;
    end else if (ce) begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign wrValid   = wr_r && ce;
  assign rdValid   = rd_r;
  assign phaseAddr = addr_r;

endmodule

// ---- hw/interrupt_flag_status_bank.sv ----
// Interrupt flag status bank: timer gate flag and port two flags.
// Assumes AHB-Lite master on clk; peripherals give one-cycle request pulses.
`timescale 1ns/10ps
module interrupt_flag_status_bank
  import flag_bank_pkg::*;
#(
  parameter bit HAS_PORT_TWO = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timerGateReq,
  input  wire logic        collisionReq,
  input  wire logic        portEventReq,
  output logic             irq
);

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic       wrValid;
  logic       rdValid;
  logic [7:0] phaseAddr;

  ahb_regs_port u_port (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .wrValid   (wrValid),
    .rdValid   (rdValid),
    .phaseAddr (phaseAddr)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = hit(a, OFS_TIMER_GATE) || hit(a, OFS_PORT_TWO)
             || hit(a, OFS_IRQ_MASK) || hit(a, OFS_IRQ_STATUS);
  endfunction

  // ----------------------------------------
  // Flag cells, one per event
  // ----------------------------------------
  logic [NUM_EVENTS-1:0] req;
  logic [NUM_EVENTS-1:0] present;
  logic [NUM_EVENTS-1:0] wrEn;
  logic [NUM_EVENTS-1:0] wrBit;
  logic [NUM_EVENTS-1:0] flags;

  assign req     = {timerGateReq, collisionReq, portEventReq};
  assign present = {1'b1, HAS_PORT_TWO, HAS_PORT_TWO};

  // ----------------------------------------
  // Write and read decode, shared with the checks
  // ----------------------------------------
  logic                  timerWr;
  logic                  portWr;
  logic                  maskWr;
  logic                  statusWr;
  logic                  rdTake;
  logic [NUM_EVENTS-1:0] wrLow;
  logic [NUM_EVENTS-1:0] setMask;
  logic [NUM_EVENTS-1:0] clrMask;

  assign timerWr  = wrValid && hit(phaseAddr, OFS_TIMER_GATE);
  assign portWr   = wrValid && hit(phaseAddr, OFS_PORT_TWO);
  assign maskWr   = wrValid && hit(phaseAddr, OFS_IRQ_MASK);
  assign statusWr = wrValid && hit(phaseAddr, OFS_IRQ_STATUS);
  assign rdTake   = ce && hsel && hready && htrans[1] && !hwrite;
  assign wrLow    = hwdata[NUM_EVENTS-1:0];
  assign setMask  = req & present;
  assign clrMask  = statusWr ? (wrLow & ~setMask) : EVENTS_RESET;

  always_comb begin
    wrEn[2]  = wrValid && hit(phaseAddr, OFS_TIMER_GATE);
    wrBit[2] = hwdata[BIT_TIMER_GATE];
    wrEn[1]  = wrValid && hit(phaseAddr, OFS_PORT_TWO);
    wrBit[1] = hwdata[BIT_COLLISION];
    wrEn[0]  = wrValid && hit(phaseAddr, OFS_PORT_TWO);
    wrBit[0] = hwdata[BIT_PORT_EVENT];
  end

  generate
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
      flag_cell u_cell (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .present  (present[i]),
        .setPulse (req[i]),
        .wrEn     (wrEn[i]),
        .wrBit    (wrBit[i]),
        .flag     (flags[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status (write one to clear) and mask
  // ----------------------------------------
  logic [NUM_EVENTS-1:0] status_r;
  logic [NUM_EVENTS-1:0] status_nxt;
  logic [NUM_EVENTS-1:0] mask_r;
  logic [NUM_EVENTS-1:0] mask_nxt;

  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (wrValid && hit(phaseAddr, OFS_IRQ_STATUS)) begin
      status_nxt = status_r & ~hwdata[NUM_EVENTS-1:0];
    end
    if (wrValid && hit(phaseAddr, OFS_IRQ_MASK)) begin
      mask_nxt = hwdata[NUM_EVENTS-1:0];
    end
    // Set beats clear so no event is lost
    status_nxt = status_nxt | (req & present);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_r <= EVENTS_RESET;
      mask_r   <= EVENTS_RESET;
    end else if (ce) begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------
  // Read data, registered at the address phase
  // ----------------------------------------
  logic [15:0] timerReg;
  logic [15:0] portReg;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    timerReg = REG_RESET;
    timerReg[BIT_TIMER_GATE] = flags[2];
    portReg = REG_RESET;
    portReg[BIT_COLLISION]  = flags[1];
    portReg[BIT_PORT_EVENT] = flags[0];
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(haddr, OFS_TIMER_GATE)) begin
      rdata_nxt = {16'h0000, timerReg};
    end else if (hit(haddr, OFS_PORT_TWO)) begin
      rdata_nxt = {16'h0000, portReg};
    end else if (hit(haddr, OFS_IRQ_MASK)) begin
      rdata_nxt = {29'h0, mask_r};
    end else if (hit(haddr, OFS_IRQ_STATUS)) begin
      rdata_nxt = {29'h0, status_r};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rdTake) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata    = rdata_r;
  // Stall while frozen, so a transfer is never dropped
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // Checks on read data
  // ----------------------------------------
  sequence s_gate_req;
    ce && timerGateReq;
  endsequence

  sequence s_collision_req;
    ce && collisionReq && HAS_PORT_TWO;
  endsequence

  sequence s_event_req;
    ce && portEventReq && HAS_PORT_TWO;
  endsequence

  sequence s_read_timer;
    rdValid && phaseAddr == OFS_TIMER_GATE;
  endsequence

  sequence s_read_port;
    rdValid && phaseAddr == OFS_PORT_TWO;
  endsequence

  a_low_bits_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_timer |-> hrdata[4:0] == 5'h00)
    else $error("timer register low bits not zero");

  a_timer_upper_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_timer |-> hrdata[31:6] == 26'h0)
    else $error("timer register upper bits not zero");

  a_high_bits_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_port |-> hrdata[15:3] == 13'h0)
    else $error("port register high bits not zero");

  a_port_upper_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_port |-> hrdata[31:16] == 16'h0000)
    else $error("port register upper half not zero");

  a_bit0_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_port |-> !hrdata[0])
    else $error("port register bit 0 not zero");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    rdValid && !is_mapped(phaseAddr) |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_read_stands: assert property (@(posedge clk) disable iff (srst)
    !rdTake |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_gate_readback: assert property (@(posedge clk) disable iff (srst)
    s_gate_req ##1 ce ##1 s_read_timer |-> hrdata[BIT_TIMER_GATE])
    else $error("timer gate flag lost");

  a_collision_readback: assert property (@(posedge clk) disable iff (srst)
    s_collision_req ##1 ce ##1 s_read_port |-> hrdata[BIT_COLLISION])
    else $error("collision flag lost");

  a_event_readback: assert property (@(posedge clk) disable iff (srst)
    s_event_req ##1 ce ##1 s_read_port |-> hrdata[BIT_PORT_EVENT])
    else $error("event flag lost");

  a_absent_read: assert property (@(posedge clk) disable iff (srst)
    !HAS_PORT_TWO && rdValid && phaseAddr == OFS_PORT_TWO |-> hrdata[2:1] == 2'h0)
    else $error("absent port flags read as set");

  // ----------------------------------------
  // Checks on the flags
  // ----------------------------------------
  a_timer_set: assert property (@(posedge clk) disable iff (srst)
    ce && timerGateReq |=> flags[2])
    else $error("timer gate flag not set");

  a_collision_set: assert property (@(posedge clk) disable iff (srst)
    ce && collisionReq && HAS_PORT_TWO |=> flags[1])
    else $error("collision flag not set");

  a_event_set: assert property (@(posedge clk) disable iff (srst)
    ce && portEventReq && HAS_PORT_TWO |=> flags[0])
    else $error("event flag not set");

  a_gate_write_one: assert property (@(posedge clk) disable iff (srst)
    timerWr && hwdata[BIT_TIMER_GATE] |=> flags[2])
    else $error("timer gate flag not written");

  a_collision_write: assert property (@(posedge clk) disable iff (srst)
    portWr && hwdata[BIT_COLLISION] && HAS_PORT_TWO |=> flags[1])
    else $error("collision flag not written");

  a_event_write: assert property (@(posedge clk) disable iff (srst)
    portWr && hwdata[BIT_PORT_EVENT] && HAS_PORT_TWO |=> flags[0])
    else $error("event flag not written");

  a_clear_holds: assert property (@(posedge clk) disable iff (srst)
    ce && wrEn[2] && !wrBit[2] && !timerGateReq |=> !flags[2])
    else $error("flag not cleared by write of zero");

  a_collision_clear: assert property (@(posedge clk) disable iff (srst)
    portWr && !hwdata[BIT_COLLISION] && !collisionReq |=> !flags[1])
    else $error("collision flag not cleared");

  a_event_clear: assert property (@(posedge clk) disable iff (srst)
    portWr && !hwdata[BIT_PORT_EVENT] && !portEventReq |=> !flags[0])
    else $error("event flag not cleared");

  a_gate_holds: assert property (@(posedge clk) disable iff (srst)
    !timerWr && flags[2] |=> flags[2])
    else $error("timer gate flag dropped");

  a_collision_holds: assert property (@(posedge clk) disable iff (srst)
    !portWr && flags[1] |=> flags[1])
    else $error("collision flag dropped");

  a_event_holds: assert property (@(posedge clk) disable iff (srst)
    !portWr && flags[0] |=> flags[0])
    else $error("event flag dropped");

  a_absent_port: assert property (@(posedge clk) disable iff (srst)
    !HAS_PORT_TWO |-> flags[1:0] == 2'h0)
    else $error("absent port flags not zero");

  a_freeze_flags: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(flags))
    else $error("flags moved while frozen");

  // ----------------------------------------
  // Checks on interrupt status and mask
  // ----------------------------------------
  a_absent_status: assert property (@(posedge clk) disable iff (srst)
    !HAS_PORT_TWO |-> status_r[1:0] == 2'h0)
    else $error("absent port status not zero");

  a_status_set: assert property (@(posedge clk) disable iff (srst)
    ce && setMask != EVENTS_RESET |=> (status_r & $past(setMask)) == $past(setMask))
    else $error("status bit not set by request");

  a_status_clear: assert property (@(posedge clk) disable iff (srst)
    ce && clrMask != EVENTS_RESET |=> (status_r & $past(clrMask)) == EVENTS_RESET)
    else $error("status bit not cleared by write of one");

  a_status_sticky: assert property (@(posedge clk) disable iff (srst)
    ce && !statusWr |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit dropped without a clear");

  a_mask_write: assert property (@(posedge clk) disable iff (srst)
    maskWr |=> mask_r == $past(wrLow))
    else $error("mask not written");

  a_mask_holds: assert property (@(posedge clk) disable iff (srst)
    ce && !maskWr |=> $stable(mask_r))
    else $error("mask changed without a write");

  a_irq_raise: assert property (@(posedge clk) disable iff (srst)
    ce && (setMask & mask_r) != EVENTS_RESET && !maskWr |=> irq)
    else $error("interrupt not raised for unmasked event");

  a_freeze_status: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(status_r) && $stable(mask_r))
    else $error("status or mask moved while frozen");

endmodule

// ---- sim/interrupt_flag_status_bank_test.sv ----
// Self-checking bench for the interrupt flag status bank.
// Assumes an AHB-Lite slave stalled by ce; a second instance is the reduced variant.
`timescale 1ns/10ps
module interrupt_flag_status_bank_test
  import flag_bank_pkg::*;
;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        ce        = 1'b1;
  logic        hsel      = 1'b1;
  logic        hwrite    = 1'b0;
  logic [7:0]  haddr     = 8'h00;
  logic [1:0]  htrans    = AHB_IDLE;
  logic [2:0]  hsize     = 3'h2;
  logic [2:0]  req       = 3'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] hrdataLite;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        timerFlag;
  logic [1:0]  portFlags;
  logic [2:0]  mask;
  logic [2:0]  status;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  interrupt_flag_status_bank i_dut (
    .clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timerGateReq(req[2]), .collisionReq(req[1]),
    .portEventReq(req[0]), .irq(irq));

  // Reduced variant shares every input so reads line up cycle for cycle
  interrupt_flag_status_bank #(.HAS_PORT_TWO(1'b0)) i_lite (
    .clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdataLite),
    .hreadyout(), .hresp(), .timerGateReq(req[2]), .collisionReq(req[1]),
    .portEventReq(req[0]), .irq());

  always #20 clk = ~clk;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      stop_test;
    end
  end

  function automatic logic [31:0] modelRead(input logic [7:0] a);
    case (a)
      OFS_TIMER_GATE: return {26'h0, timerFlag, 5'h0};
      OFS_PORT_TWO:   return {29'h0, portFlags, 1'b0};
      OFS_IRQ_MASK:   return {29'h0, mask};
      OFS_IRQ_STATUS: return {29'h0, status};
      default:        return 32'h0;
    endcase
  endfunction

  // ----------------------------------------
  // Bus master and model update
  // ----------------------------------------
  // Request pulse p lands in the data phase, the same cycle as a write
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] p);
    haddr  <= a;
    hwrite <= w;
    htrans <= AHB_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= AHB_IDLE;
    hwdata <= d;
    req    <= p;
    @(posedge clk);
    req <= 3'h0;
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    if (w && hsel) begin
      case (a)
        OFS_TIMER_GATE: timerFlag = d[5];
        OFS_PORT_TWO:   portFlags = d[2:1];
        OFS_IRQ_MASK:   mask = d[2:0];
        OFS_IRQ_STATUS: status = status & ~d[2:0];
        default:        ;
      endcase
    end
    // Hardware set beats the same-cycle software write
    timerFlag = timerFlag | p[2];
    portFlags = portFlags | p[1:0];
    status    = status | p;
  endtask

  task automatic check_reg(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0, 3'h0);
    chk(rd, modelRead(a));
    if (a == OFS_PORT_TWO) chk(hrdataLite, 32'h0);
    else if (a == OFS_TIMER_GATE) chk(hrdataLite, modelRead(a));
    chk(hresp, 32'h0);
    chk(irq, |(status & mask));
  endtask

  task automatic reset_all;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst      <= 1'b0;
    timerFlag = 1'b0;
    portFlags = 2'h0;
    mask      = 3'h0;
    status    = 3'h0;
    for (int i = 0; i < 5; i++) check_reg(8'(i * 4));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hDC5BC582));
    @(posedge clk);
    reset_all;
    // Ones everywhere show only implemented bits, then a zero write clears the timer gate flag
    for (int i = 0; i < 4; i++) begin
      xfer(8'(i * 4), 1'b1, 32'hFFFFFFFF, 3'h0);
      check_reg(8'(i * 4));
    end
    xfer(OFS_TIMER_GATE, 1'b1, 32'h0, 3'h0);
    check_reg(OFS_TIMER_GATE);
    xfer(8'h10, 1'b1, 32'hFFFFFFFF, 3'h7);
    for (int i = 0; i < 3; i++) begin
      check_reg(OFS_IRQ_STATUS);
      xfer(OFS_IRQ_STATUS, 1'b1, 32'(1 << i), 3'h0);
    end
    check_reg(OFS_IRQ_STATUS);
    // Clear write racing a request pulse
    xfer(OFS_PORT_TWO, 1'b1, 32'h0, 3'h2);
    check_reg(OFS_PORT_TWO);
    xfer(OFS_TIMER_GATE, 1'b1, 32'h0, 3'h4);
    check_reg(OFS_TIMER_GATE);
    xfer(OFS_IRQ_STATUS, 1'b1, 32'h7, 3'h1);
    check_reg(OFS_IRQ_STATUS);
    for (int i = 0; i < 60; i++) begin
      xfer(8'($urandom_range(4) * 4), 1'($urandom_range(1)), $urandom,
           3'($urandom_range(7)));
      check_reg(8'($urandom_range(4) * 4));
    end
    // Clock enable low: requests ignored, a write stalls until it returns
    ce  <= 1'b0;
    req <= 3'h7;
    @(posedge clk);
    req <= 3'h0;
    fork
      xfer(OFS_IRQ_MASK, 1'b1, 32'h5, 3'h0);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    for (int i = 0; i < 4; i++) check_reg(8'(i * 4));
    // Deselected write leaves the mask alone
    hsel <= 1'b0;
    xfer(OFS_IRQ_MASK, 1'b1, 32'h0, 3'h0);
    hsel <= 1'b1;
    check_reg(OFS_IRQ_MASK);
    // Reset in mid-run with flags set
    xfer(OFS_PORT_TWO, 1'b1, 32'h6, 3'h7);
    reset_all;
    stop_test;
  end
endmodule
